// [hw/dsf_pkg.sv]
// Shared constants for the decimator status and flag block
package dsf_pkg;
   // Status word layout
   localparam int STAT_BITS      = 16;
   localparam int DATA_BITS      = 24;
   localparam int PTR_W          = 5;
   localparam int B_ERR_SUM      = 15;
   localparam int B_OVERWRITE    = 14;
   localparam int B_MOD_FLAG     = 13;
   localparam int B_STAGE1       = 12;
   localparam int B_STAGE23      = 11;
   localparam int B_WORD_AVAIL   = 10;
   localparam int B_FIRST_SAMPLE = 9;
   localparam int B_CAL_DONE     = 8;
   localparam int B_POWER_DOWN   = 7;
   localparam int B_CAL_REQUEST  = 6;
   localparam int B_APPLY_OFFSET = 5;
   localparam int B_SOURCE_SEL   = 4;
   localparam int B_RESERVED     = 3;
   // Configuration byte layout, power-down in the top bit
   localparam int CFG_POWER_DOWN = 7;
   localparam int CFG_CAL_REQ    = 6;
   localparam int CFG_APPLY_OFS  = 5;
   localparam int CFG_SOURCE_SEL = 4;
   // Decimation
   localparam int DECIM_CLOCKS_MAX = 16384;
   localparam int CNT_W            = 15;
   localparam logic [2:0] DECIM_RESERVED = 3'h7;
   // Sample counting
   localparam logic [1:0] FIRST_SAMPLE_IDX = 2'h2;
   localparam logic [5:0] CAL_DONE_WORD    = 6'h39;
   localparam logic [5:0] ONES_RUN_LIMIT   = 6'h20;
   localparam logic [7:0] STAT_PAD         = 8'h00;
endpackage

// [hw/dsf_status_top.sv]
// Status word, error flags, data-ready and serial read path of the filter
`timescale 1ns/1ps
module dsf_status_top #(
   parameter int DECIM_MAX = dsf_pkg::DECIM_CLOCKS_MAX
) (
   // Filter input clock and hard reset
   input  wire logic                       core_clk_in,
   input  wire logic                       rst_in,
   // Serial read port, serial clock is its own domain
   input  wire logic                       sclk_in,
   input  wire logic                       cs_n_in,
   input  wire logic                       read_not_write_in,
   input  wire logic                       reg_select_in,
   output logic                            serial_out_pin_out,
   output logic                            serial_out_pin_oe_out,
   // Error summary pin, open drain, active low
   output logic                            error_n_out,
   output logic                            error_n_oe_out,
   // Data-ready pin
   output logic                            word_available_out,
   // Filter bit sources and timing pins
   input  wire logic                       modulator_bitstream_in,
   input  wire logic                       test_data_in,
   input  wire logic                       modulator_unstable_flag_in,
   input  wire logic                       sync_in,
   // Stage two and three overflow from the filter core
   input  wire logic                       stage23_overflow_in,
   // Converted word from the filter core, same clock
   input  wire logic [dsf_pkg::DATA_BITS-1:0] conv_word_in,
   // Configuration pins and written configuration byte
   input  wire logic                       hw_sw_select_in,
   input  wire logic                       power_down_ctl_in,
   input  wire logic                       offset_cal_request_in,
   input  wire logic                       apply_offset_correction_in,
   input  wire logic                       filter_source_select_in,
   input  wire logic [2:0]                 decim_code_in,
   input  wire logic [7:0]                 config_written_in,
   // Selected filter input bit
   output logic                            filter_bit_out
);
   localparam int DB = dsf_pkg::DATA_BITS;

   // Synchronised pin levels
   logic [6:0]  pins_s;        // cfg pins + hw/sw select
   logic [2:0]  dec_pin_s;     // Decimation pins
   logic [4:0]  misc_s;        // Flag, sync, bit sources, stage23
   localparam int PTR_WIDTH = dsf_pkg::PTR_W;
   logic [3:0]  link_s;        // cs_n, rw and the two link toggles
   logic        rsel_s;        // Register select pin, synchronised
   logic        seen_fall;     // Link: first falling edge seen
   logic        fall_tgl;      // Link: flips on each first fall
   logic        lsb_tgl;       // Link: flips on each LSB fall
   logic        link_clr;      // Link: deselect or hard reset
   logic [PTR_WIDTH-1:0] ptr;  // Link: bits shifted so far

   dsf_sync #(.W(7)) u_sync_cfg (
      .clk_in   (core_clk_in),
      .rst_in   (rst_in),
      .async_in ({hw_sw_select_in, power_down_ctl_in,
                  offset_cal_request_in, apply_offset_correction_in,
                  filter_source_select_in, 2'h0}),
      .sync_out (pins_s)
   );
   dsf_sync #(.W(3)) u_sync_dec (
      .clk_in   (core_clk_in),
      .rst_in   (rst_in),
      .async_in (decim_code_in),
      .sync_out (dec_pin_s)
   );
   dsf_sync #(.W(5)) u_sync_misc (
      .clk_in   (core_clk_in),
      .rst_in   (rst_in),
      .async_in ({modulator_unstable_flag_in, sync_in,
                  modulator_bitstream_in, test_data_in,
                  stage23_overflow_in}),
      .sync_out (misc_s)
   );
   dsf_sync #(.W(4)) u_sync_link (
      .clk_in   (core_clk_in),
      .rst_in   (rst_in),
      .async_in ({cs_n_in, read_not_write_in, fall_tgl, lsb_tgl}),
      .sync_out (link_s)
   );
   // Register select is a pin as well, so it is synchronised too
   dsf_sync #(.W(1)) u_sync_rsel (
      .clk_in   (core_clk_in),
      .rst_in   (rst_in),
      .async_in (reg_select_in),
      .sync_out (rsel_s)
   );

   // Named views of the synchronised levels
   wire hw_mode   = pins_s[6];
   wire mflag_s   = misc_s[4];
   wire sync_s    = misc_s[3];
   wire stage23_s = misc_s[0];
   wire cs_n_s    = link_s[3];
   wire rw_s      = link_s[2];
   wire fall_s    = link_s[1];
   wire lsb_s     = link_s[0];

   // Previous values for edge detection, from second stages except cal_req_q in software mode
   logic sync_q, fall_q, lsb_q, cs_n_q, cal_req_q;

   // Configuration echo source
   // pins or config
   wire [7:0] cfg_pins = {pins_s[5:2], 1'b0, dec_pin_s};
   wire [7:0] cfg_eff  = hw_mode ? cfg_pins : config_written_in;
   wire [2:0] dec_code = cfg_eff[2:0];
   wire       cal_req  = cfg_eff[dsf_pkg::CFG_CAL_REQ];

   // Selected filter input
   // source select
   assign filter_bit_out = cfg_eff[dsf_pkg::CFG_SOURCE_SEL] ?
                           misc_s[1] : misc_s[2];

   // Event decode
   wire sync_evt   = sync_s & ~sync_q;
   // Any flip of a link toggle is one event
   wire fall_rise  = fall_s ^ fall_q;
   wire lsb_rise   = lsb_s ^ lsb_q;
   wire cs_fall    = ~cs_n_s & cs_n_q;
   logic rd_is_data;                        // Latched register select
   wire data_fall  = fall_rise & rd_is_data;
   wire stat_read  = fall_rise & ~rd_is_data;
   wire data_lsb   = lsb_rise & rd_is_data;

   // Clocks per output word from the decimation code
   // decimation map
   function automatic logic [dsf_pkg::CNT_W-1:0] word_period(
      input logic [2:0] code);
      word_period = dsf_pkg::CNT_W'(DECIM_MAX >> code);
   endfunction

   // Decimation and sample state
   logic [dsf_pkg::CNT_W-1:0] dcnt;         // Clocks within the word
   logic                      running;      // Convolutions started
   logic                      power_down;   // Power-down state
   logic [1:0]                samp_idx;     // Samples since sync, sat
   logic                      first_flag;   // First-sample marker
   logic                      cal_armed;    // Calibrate request seen
   logic                      cal_active;   // Calibration running
   logic [5:0]                cal_words;    // Words since cal start
   logic                      cal_done;     // Offset sample present
   logic [5:0]                ones_run;     // Run of ones into stage 1

   wire period_end = (dcnt == word_period(dec_code) - 1'b1);
   // Reserved decimation code produces no periodic output words; a sync event still gives one
   wire word_tick  = sync_evt | (running & ~power_down & period_end &
                     (dec_code != dsf_pkg::DECIM_RESERVED));

   // Edge history registers
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         sync_q    <= 1'b0;
         fall_q    <= 1'b0;
         lsb_q     <= 1'b0;
         cs_n_q    <= 1'b0;  // Same as the synchroniser, no false edge
         cal_req_q <= 1'b0;
      end else begin
         sync_q    <= sync_s;
         fall_q    <= fall_s;
         lsb_q     <= lsb_s;
         cs_n_q    <= cs_n_s;
         cal_req_q <= cal_req;
      end
   end

   // Word counter; a sync event realigns it and, unless powered down, starts convolutions
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         dcnt       <= '0;
         running    <= 1'b0;
         power_down <= 1'b0;
      end else begin
         power_down <= cfg_eff[dsf_pkg::CFG_POWER_DOWN];
         if (sync_evt) begin
            dcnt    <= '0;
            running <= ~power_down;
         end else if (power_down) begin
            running <= 1'b0;
         end else if (word_tick) begin
            dcnt <= '0;
         end else begin
            dcnt <= dcnt + 1'b1;
         end
      end
   end

   // Sample index after sync; marker valid only for that sample
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         samp_idx   <= '0;
         first_flag <= 1'b0;
      end else if (word_tick) begin
         samp_idx   <= sync_evt ? 2'h1 :
                       (samp_idx == 2'h3 ? samp_idx : samp_idx + 1'b1);
         first_flag <= ~sync_evt & (samp_idx == 2'h1);
      end
   end

   // Offset calibration: arm on request edge, start on sync
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         cal_armed  <= 1'b0;
         cal_active <= 1'b0;
         cal_words  <= '0;
         cal_done   <= 1'b0;
      end else begin
         if (cal_req & ~cal_req_q) begin
            cal_armed <= 1'b1;
         end else if (sync_evt & cal_armed) begin
            cal_armed  <= 1'b0;
            cal_active <= 1'b1;
            cal_words  <= '0;
         end
         if (word_tick & cal_active & ~sync_evt) begin
            cal_words <= cal_words + 1'b1;
            if (cal_words + 1'b1 == dsf_pkg::CAL_DONE_WORD) begin
               cal_active <= 1'b0;
               cal_done   <= 1'b1;
            end
         end else if (word_tick) begin
            cal_done <= 1'b0;
         end
      end
   end

   // Consecutive ones into stage one; a long run is its overflow
   always_ff @(posedge core_clk_in) begin
      if (rst_in | ~filter_bit_out) begin
         ones_run <= '0;
      end else if (ones_run <= dsf_pkg::ONES_RUN_LIMIT) begin
         ones_run <= ones_run + 1'b1;
      end
   end
   wire stage1_cond = (ones_run > dsf_pkg::ONES_RUN_LIMIT);

   // Data register, attempt tracking and data-ready
   logic [DB-1:0] data_reg;        // Conversion word for serial reads
   logic          attempt;         // Data read in progress or aborted
   logic          word_avail;      // Data-ready level
   logic          pulse_p;         // Load toggle, rising edge
   logic          pulse_n;         // Load toggle copy, falling edge
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         data_reg   <= '0;
         attempt    <= 1'b0;
         word_avail <= 1'b0;
         pulse_p    <= 1'b0;
      end else if (word_tick & ~attempt) begin
         data_reg   <= conv_word_in;
         word_avail <= 1'b1;
         pulse_p    <= ~pulse_p;
         attempt    <= data_fall;
      end else begin
         if (data_lsb) begin
            word_avail <= 1'b0;
            attempt    <= 1'b0;
         end else if (data_fall) begin
            attempt <= 1'b1;
         end
      end
   end
   // Falling-edge copy closes the load pulse after half a clock
   always_ff @(negedge core_clk_in) begin
      pulse_n <= pulse_p;
   end
   assign word_available_out = word_avail & ~(pulse_p ^ pulse_n);

   // Error flags: a set in the clearing cycle wins over the clear
   logic ovw_err, modulator_unstable_flag_err, stg1_err, stg23_err;
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         ovw_err   <= 1'b0;
         modulator_unstable_flag_err  <= 1'b0;
         stg1_err  <= 1'b0;
         stg23_err <= 1'b0;
      end else begin
         ovw_err   <= (word_tick & attempt) | (ovw_err & ~stat_read);
         modulator_unstable_flag_err  <= mflag_s | (modulator_unstable_flag_err & ~stat_read);
         stg1_err  <= stage1_cond | (stg1_err & ~stat_read);
         stg23_err <= stage23_s | (stg23_err & ~stat_read);
      end
   end

   // Error summary bit and open-drain pin
   // error OR
   wire err_any = ovw_err | modulator_unstable_flag_err | stg1_err | stg23_err;
   assign error_n_out    = 1'b0;
   assign error_n_oe_out = err_any;

   // Status word assembly
   // word layout
   wire [dsf_pkg::STAT_BITS-1:0] status_word = {
      err_any, ovw_err, modulator_unstable_flag_err, stg1_err, stg23_err,
      word_avail, first_flag, cal_done,
      power_down, cal_req,
      cfg_eff[dsf_pkg::CFG_APPLY_OFS] & ~cal_active,
      cfg_eff[dsf_pkg::CFG_SOURCE_SEL], 1'b0, dec_code};

   // Snapshot of the selected word when a read select is seen.
   // Held still for the whole read so the link reads stable bits.
   logic [DB-1:0] shift_word;
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         shift_word <= '0;
         rd_is_data <= 1'b0;
      end else if (cs_fall & rw_s) begin
         rd_is_data <= rsel_s;
         shift_word <= rsel_s ? data_reg :
                       {status_word, dsf_pkg::STAT_PAD};
      end
   end

   // Link domain: deselect or hard reset clears the bit pointer
   assign link_clr = cs_n_in | rst_in;
   always_ff @(negedge sclk_in or posedge link_clr) begin
      if (link_clr) begin
         seen_fall <= 1'b0;
      end else if (read_not_write_in) begin
         seen_fall <= 1'b1;
      end
   end
   // Read events travel as toggles: a level cleared by cs_n could be
   // gone before the slower core clock samples it
   always_ff @(negedge sclk_in or posedge rst_in) begin
      if (rst_in) begin
         fall_tgl <= 1'b0;
         lsb_tgl  <= 1'b0;
      end else if (~cs_n_in & read_not_write_in) begin
         fall_tgl <= fall_tgl ^ ~seen_fall;
         lsb_tgl  <= lsb_tgl ^ (ptr == PTR_WIDTH'(DB - 1));
      end
   end
   // Each rising edge after the first fall shifts a new bit, until ptr reaches DB
   always_ff @(posedge sclk_in or posedge link_clr) begin
      if (link_clr) begin
         ptr <= '0;
      end else if (seen_fall & (ptr != PTR_WIDTH'(DB))) begin
         ptr <= ptr + 1'b1;
      end
   end

   // Serial output bit; status repeats its LSB, data pads zeros
   // MSB first
   wire stat_over = ~rd_is_data & (ptr >= PTR_WIDTH'(dsf_pkg::STAT_BITS));
   wire data_over = rd_is_data & (ptr >= PTR_WIDTH'(DB));
   wire [PTR_WIDTH-1:0] bit_idx = PTR_WIDTH'(DB - 1) - ptr;
   assign serial_out_pin_out = stat_over ? shift_word[DB-dsf_pkg::STAT_BITS]
                             : (data_over ? 1'b0 : shift_word[bit_idx]);
   assign serial_out_pin_oe_out = ~cs_n_in & read_not_write_in;

   // Checks on the core clock
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   property p_err_pin;
      err_any |-> error_n_oe_out && status_word[dsf_pkg::B_ERR_SUM];
   endproperty
   a_err_pin: assert property (p_err_pin) else $error("error pin wrong");

   property p_ovw_set;
      word_tick && attempt |=> ovw_err && word_avail;
   endproperty
   a_ovw_set: assert property (p_ovw_set) else $error("overwrite missed");

   property p_keep_old;
      word_tick && attempt && !data_lsb |=> $stable(data_reg);
   endproperty
   a_keep_old: assert property (p_keep_old) else $error("old word lost");

   property p_load;
      word_tick && !attempt |=> data_reg == $past(conv_word_in)
                               && word_avail;
   endproperty
   a_load: assert property (p_load) else $error("new word not loaded");

   property p_rdy_fall;
      data_lsb && !(word_tick && !attempt) |=> !word_avail[*2];
   endproperty
   a_rdy_fall: assert property (p_rdy_fall) else $error("ready stuck");

   property p_pulse;
      word_tick && !attempt |=> pulse_p != $past(pulse_p);
   endproperty
   a_pulse: assert property (p_pulse) else $error("no ready pulse");

   property p_modulator_unstable_flag;
      mflag_s && stat_read |=> modulator_unstable_flag_err;
   endproperty
   a_modulator_unstable_flag: assert property (p_modulator_unstable_flag) else $error("flag cleared early");

   property p_ofs_echo;
      cal_active |-> !status_word[dsf_pkg::B_APPLY_OFFSET]
                     && !status_word[dsf_pkg::B_RESERVED];
   endproperty
   a_ofs_echo: assert property (p_ofs_echo) else $error("echo wrong");

   property p_first;
      first_flag |-> samp_idx == dsf_pkg::FIRST_SAMPLE_IDX;
   endproperty
   a_first: assert property (p_first) else $error("marker misplaced");

   property p_rst_clear;
      @(posedge core_clk_in) rst_in |=> !ovw_err && !modulator_unstable_flag_err
                                         && !stg1_err && !stg23_err;
   endproperty
   a_rst_clear: assert property (disable iff (1'b0) p_rst_clear)
      else $error("flags survive reset");
endmodule

// [hw/dsf_sync.sv]
// Two flip-flop level synchroniser, any width
`timescale 1ns/1ps
module dsf_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   // Level in and synchronised level out
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] stage1;   // First stage, read only by the second

   // Both stages clear on reset so the first edges see a known low
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         stage1   <= '0;
         sync_out <= '0;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

// [tb/decimator_status_flags_bench.sv]
// Self-checking bench for the status word and flag logic
`timescale 1ns/1ps
module decimator_status_flags_bench;
   localparam int DM = 64;            // Short decimation count
   logic        core_clk_in = 1'b0;   // Filter clock
   logic        rst_in = 1'b0;        // Hard reset, raised at 1 ns
   logic        sclk, cs_n, rnw, rsel; // Host serial pins
   logic        serial_out_pin, sod_oe, err_n, err_oe, ready, fbit;
   logic        mbit = 1'b0, tbit = 1'b0, mflag = 1'b0, syn = 1'b0;
   logic        s23 = 1'b0, hws = 1'b1, pd = 1'b0, cal = 1'b0;
   logic        ofs = 1'b1, src = 1'b0;
   logic [2:0]  dec = 3'h0;           // Longest period
   logic [7:0]  cfgw = 8'h00;
   logic [23:0] conv = 24'ha5c3e1, rv;
   int          errors = 0, samples_checked = 0;
   time         t1;
   // Pull-up holds the line high when released
   wire         sod_line = sod_oe ? serial_out_pin : 1'b1;

   always #25 core_clk_in = ~core_clk_in;

   dsf_status_top #(.DECIM_MAX(DM)) i_dut (
      .core_clk_in(core_clk_in), .rst_in(rst_in), .sclk_in(sclk),
      .cs_n_in(cs_n), .read_not_write_in(rnw), .reg_select_in(rsel),
      .serial_out_pin_out(serial_out_pin), .serial_out_pin_oe_out(sod_oe),
      .error_n_out(err_n), .error_n_oe_out(err_oe),
      .word_available_out(ready), .modulator_bitstream_in(mbit),
      .test_data_in(tbit), .modulator_unstable_flag_in(mflag),
      .sync_in(syn), .stage23_overflow_in(s23), .conv_word_in(conv),
      .hw_sw_select_in(hws), .power_down_ctl_in(pd),
      .offset_cal_request_in(cal), .apply_offset_correction_in(ofs),
      .filter_source_select_in(src), .decim_code_in(dec),
      .config_written_in(cfgw), .filter_bit_out(fbit));

   dsf_host_model i_host (
      .sclk_out(sclk), .cs_n_out(cs_n), .read_not_write_out(rnw),
      .reg_select_out(rsel), .sod_in(sod_line));

   // Word and bit comparisons
   task automatic chk(input logic [23:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chkb(input logic got, exp);
      chk({23'h0, got}, {23'h0, exp});
   endtask

   // Serial read into rv
   task automatic rd(input logic sel, input int n);
      i_host.read_bits(sel, n, rv);
   endtask

   // Bounded wait for the ready pin level
   task automatic wait_ready(input logic lvl);
      int n;
      n = 0;
      while (ready !== lvl && n < 400) begin
         @(negedge core_clk_in);
         n++;
      end
      if (n >= 400) begin
         errors++;
         $display("[FAIL] t=%0t ready=%h exp=%h", $time, ready, lvl);
         wrap_up();
      end
   endtask

   task automatic wrap_up;
      $display("Checked %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Main sequence, inputs moved at falling edges or right after a read
   initial begin
      // Raised after time zero so processes waiting on its edge see it
      #1 rst_in = 1'b1;
      repeat (6) @(negedge core_clk_in);
      rst_in = 1'b0;
      repeat (4) @(negedge core_clk_in);
      rd(1'b0, 16);
      chk(rv, 24'h000020);
      // Software mode echo; extra clocks repeat the LSB
      hws  = 1'b0;
      cfgw = 8'h11;
      tbit = 1'b1;
      repeat (4) @(negedge core_clk_in);
      chkb(fbit, 1'b1);
      tbit = 1'b0;
      rd(1'b0, 18);
      chk(rv, 24'h000047);
      hws = 1'b1;
      $display("test echo done");
      syn = 1'b1;
      repeat (2) @(negedge core_clk_in);
      syn = 1'b0;
      wait_ready(1'b1);
      t1 = $time;
      rd(1'b1, 24);
      chk(rv, 24'ha5c3e1);
      chkb(ready, 1'b0);
      conv = 24'h3c5a96;
      wait_ready(1'b1);
      chk(24'($time - t1), 24'(DM * 50));
      // Second word after sync carries the marker, ready still high
      rd(1'b0, 16);
      chk({22'h0, rv[10:9]}, 24'h000003);
      $display("test data done");
      // Aborted data read, then a new word arrives
      conv = 24'h0f0f0f;
      rd(1'b1, 4);
      repeat (DM / 2) @(negedge core_clk_in);
      chkb(ready, 1'b1);
      chkb(err_oe, 1'b1);
      rd(1'b0, 16);
      chk({22'h0, rv[15:14]}, 24'h000003);
      rd(1'b1, 24);
      chk(rv, 24'h3c5a96);
      rd(1'b0, 16);
      chk({22'h0, rv[15:14]}, 24'h000000);
      $display("test overwrite done");
      // Sticky flags clear only once their cause is gone
      for (int s = 0; s < 2; s++) begin
         mflag = (s == 0);
         s23   = (s == 1);
         repeat (4) @(negedge core_clk_in);
         rd(1'b0, 16);
         chk({22'h0, rv[13], rv[11]}, {22'h0, mflag, s23});
         rd(1'b0, 16);
         chk({22'h0, rv[13], rv[11]}, {22'h0, mflag, s23});
         mflag = 1'b0;
         s23   = 1'b0;
         repeat (4) @(negedge core_clk_in);
         rd(1'b0, 16);
         chk({22'h0, rv[13], rv[11]}, {22'h0, s == 0, s == 1});
         rd(1'b0, 16);
         chk({22'h0, rv[13], rv[11]}, 24'h000000);
      end
      $display("test sticky done");
      // Ones run on the test input: 30 is harmless, 40 is not
      src = 1'b1;
      for (int r = 30; r <= 40; r += 10) begin
         tbit = 1'b1;
         repeat (r) @(negedge core_clk_in);
         chkb(fbit, 1'b1);
         tbit = 1'b0;
         repeat (4) @(negedge core_clk_in);
         rd(1'b0, 16);
         chkb(rv[dsf_pkg::B_STAGE1], r > 32);
      end
      rd(1'b0, 16);
      chkb(rv[dsf_pkg::B_STAGE1], 1'b0);
      src  = 1'b0;
      tbit = 1'b1;
      repeat (4) @(negedge core_clk_in);
      chkb(fbit, 1'b0);
      tbit = 1'b0;
      $display("test stage one done");
      // Mid-run hard reset wipes a latched flag
      mflag = 1'b1;
      repeat (4) @(negedge core_clk_in);
      mflag  = 1'b0;
      rst_in = 1'b1;
      repeat (6) @(negedge core_clk_in);
      rst_in = 1'b0;
      repeat (4) @(negedge core_clk_in);
      chkb(err_oe, 1'b0);
      rd(1'b0, 16);
      chk({19'h0, rv[15:11]}, 24'h000000);
      $display("test reset done");
      wrap_up();
   end
endmodule

// [tb/dsf_host_model.sv]
// Host processor model that reads the filter over the serial port
`timescale 1ns/1ps
module dsf_host_model (
   // Serial read pins driven by the host
   output logic      sclk_out,
   output logic      cs_n_out,
   output logic      read_not_write_out,
   output logic      reg_select_out,
   // Resolved serial data line
   input  wire logic sod_in
);
   // Idle frame: serial clock parked high, chip deselected
   initial begin
      sclk_out           = 1'b1;
      cs_n_out           = 1'b1;
      read_not_write_out = 1'b1;
      reg_select_out     = 1'b0;
   end

   // One framed read of nbits; the serial clock only moves inside it
   task automatic read_bits(input logic rsel, input int nbits,
                            output logic [23:0] val);
      val            = 24'h000000;
      reg_select_out = rsel;
      cs_n_out       = 1'b0;
      // Core needs six of its clocks before the first falling edge
      #300;
      for (int k = 0; k < nbits; k++) begin
         sclk_out = 1'b0;
         #8;
         val = {val[22:0], sod_in};
         #8;
         sclk_out = 1'b1;
         #16;
      end
      // Deselect and keep the gap the core needs between reads
      cs_n_out = 1'b1;
      #300;
   endtask
endmodule
